// ==== design/ire_redirect.sv ====
// redirection table with apb access and interrupt message launch
`timescale 1ns/1ps
`include "ire_map.svh"
module ire_redirect #(
  parameter int NUM_IRQ = 24,
  parameter int ADDR_W  = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_IRQ-1:0] irq_in,
  output logic                    msg_valid,
  input  wire logic               msg_ready,
  output logic      [31:0]        msg_addr,
  output logic      [7:0]         msg_vector,
  output logic      [2:0]         msg_kind,
  output logic                    msg_logical,
  output logic      [3:0]         msg_phys_target
);
  localparam int SEL_W = $clog2(NUM_IRQ + 1);

  if (NUM_IRQ < 1 || NUM_IRQ > `IRE_MAX_IRQ) begin : g_bad_irq
    $error("NUM_IRQ must lie between 1 and 24");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  logic [NUM_IRQ-1:0][31:0] lo_words;
  logic [NUM_IRQ-1:0][31:0] hi_words;
  logic [NUM_IRQ-1:0][7:0]  vecs;
  logic [NUM_IRQ-1:0][2:0]  kinds;
  logic [NUM_IRQ-1:0]       dstms;
  logic [NUM_IRQ-1:0][7:0]  dids;
  logic [NUM_IRQ-1:0][7:0]  edids;
  logic [NUM_IRQ-1:0]       reqs;
  logic [NUM_IRQ-1:0]       wr_lo;
  logic [NUM_IRQ-1:0]       wr_hi;
  logic [NUM_IRQ-1:0]       acks;

  // ---- apb decode ----
  logic [5:0]  idx;
  logic [5:0]  rel;
  logic [4:0]  ent;
  logic        is_hi;
  logic        mapped;
  logic        acc;
  logic [31:0] rd_word;
  logic [31:0] prdata_ff, nxt_prdata;

  assign idx   = paddr[7:2];
  assign rel   = idx - `IRE_IDX_LO_FIRST;
  assign ent   = rel[5:1];
  assign is_hi = idx[0];
  // byte address is four times the word index; high halves at 11h, 13h .. 3Fh
  // a shift rather than a part-select, so the test also holds when ADDR_W is exactly 8
  assign mapped = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0) &&
                  (idx >= `IRE_IDX_LO_FIRST) && (idx <= `IRE_IDX_LAST) &&
                  (32'(ent) < 32'(NUM_IRQ));
  assign acc    = psel & penable;

  always_comb begin
    rd_word = 32'h0000_0000;
    for (int n = 0; n < NUM_IRQ; n++) begin
      if (mapped && 32'(ent) == 32'(n)) begin
        rd_word = is_hi ? hi_words[n] : lo_words[n];
      end
    end
  end

  // read data is captured in the setup cycle so it comes from a flip-flop
  always_comb begin
    nxt_prdata = prdata_ff;
    if (psel && !penable) begin
      nxt_prdata = pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  always_comb begin
    for (int n = 0; n < NUM_IRQ; n++) begin
      wr_lo[n] = acc && pwrite && mapped && !is_hi && (32'(ent) == 32'(n));
      wr_hi[n] = acc && pwrite && mapped && is_hi && (32'(ent) == 32'(n));
    end
  end

  // ---- entries ----
  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_entry
    ire_entry u_entry (
      .pclk                       (pclk),
      .presetn                    (presetn),
      .wr_lo                      (wr_lo[g]),
      .wr_hi                      (wr_hi[g]),
      .wdata                      (pwdata),
      .ack                        (acks[g]),
      .irq_in                     (irq_in[g]),
      .lo_word                    (lo_words[g]),
      .hi_word                    (hi_words[g]),
      .req                        (reqs[g]),
      .interrupt_vector_field     (vecs[g]),
      .delivery_kind_field        (kinds[g]),
      .target_addressing_mode     (dstms[g]),
      .target_identifier          (dids[g]),
      .extended_target_identifier (edids[g])
    );
  end

  // ---- message launch ----
  ire_pkg::ire_state_e state_ff, nxt_state;
  logic [SEL_W-1:0]    sel_ff, nxt_sel;
  logic [31:0]         addr_ff, nxt_addr;
  logic [7:0]          vec_ff, nxt_vec;
  logic [2:0]          kind_ff, nxt_kind;
  logic                logical_ff, nxt_logical;
  logic [3:0]          phys_ff, nxt_phys;
  logic                found;
  logic [SEL_W-1:0]    pick;

  // lowest-numbered requesting input wins
  always_comb begin
    found = 1'b0;
    pick  = '0;
    for (int n = NUM_IRQ - 1; n >= 0; n--) begin
      if (reqs[n]) begin
        found = 1'b1;
        pick  = SEL_W'(n);
      end
    end
  end

  always_comb begin
    nxt_state   = state_ff;
    nxt_sel     = sel_ff;
    nxt_addr    = addr_ff;
    nxt_vec     = vec_ff;
    nxt_kind    = kind_ff;
    nxt_logical = logical_ff;
    nxt_phys    = phys_ff;
    acks        = '0;
    case (state_ff)
      ire_pkg::IRE_ST_IDLE: begin
        if (found) begin
          nxt_state   = ire_pkg::IRE_ST_SEND;
          nxt_sel     = pick;
          nxt_addr    = {`IRE_MSG_BASE, dids[pick], edids[pick], 1'b0,
                         dstms[pick], 2'b00};
          nxt_vec     = vecs[pick];
          nxt_kind    = kinds[pick];
          nxt_logical = dstms[pick];
          // physical targets use only the low nibble of the identifier
          nxt_phys    = dstms[pick] ? 4'h0 : dids[pick][3:0];
        end
      end
      ire_pkg::IRE_ST_SEND: begin
        if (msg_ready) begin
          nxt_state    = ire_pkg::IRE_ST_IDLE;
          acks[sel_ff] = 1'b1;
        end
      end
      default: begin
        nxt_state = ire_pkg::IRE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= ire_pkg::IRE_ST_IDLE;
      sel_ff     <= '0;
      addr_ff    <= 32'h0000_0000;
      vec_ff     <= `IRE_VEC_RST;
      kind_ff    <= `IRE_DELIVERY_KIND_FIELD_RST;
      logical_ff <= 1'b0;
      phys_ff    <= 4'h0;
    end else begin
      state_ff   <= nxt_state;
      sel_ff     <= nxt_sel;
      addr_ff    <= nxt_addr;
      vec_ff     <= nxt_vec;
      kind_ff    <= nxt_kind;
      logical_ff <= nxt_logical;
      phys_ff    <= nxt_phys;
    end
  end

  // a message once launched is not withdrawn if the entry is masked meanwhile
  assign msg_valid       = (state_ff == ire_pkg::IRE_ST_SEND);
  assign msg_addr        = addr_ff;
  assign msg_vector      = vec_ff;
  assign msg_kind        = kind_ff;
  assign msg_logical     = logical_ff;
  assign msg_phys_target = phys_ff;
endmodule : ire_redirect

// ==== design/ire_map.svh ====
// register map, field positions and reset values of the redirection entries
`ifndef IRE_MAP_SVH
`define IRE_MAP_SVH
`define IRE_IDX_LO_FIRST   6'h10
`define IRE_IDX_HI_FIRST   6'h11
`define IRE_IDX_LAST       6'h3f
`define IRE_VEC_MSB        7
`define IRE_VEC_LSB        0
`define IRE_DELIVERY_KIND_FIELD_MSB       10
`define IRE_DELIVERY_KIND_FIELD_LSB       8
`define IRE_TARGET_ADDRESSING_MODE_BIT       11
`define IRE_PEND_BIT       12
`define IRE_MASK_BIT       16
`define IRE_DID_MSB        31
`define IRE_DID_LSB        24
`define IRE_EXTENDED_TARGET_IDENTIFIER_MSB       23
`define IRE_EXTENDED_TARGET_IDENTIFIER_LSB       16
`define IRE_MASK_RST       1'b1
`define IRE_VEC_RST        8'h00
`define IRE_DELIVERY_KIND_FIELD_RST       3'h0
`define IRE_ID_RST         8'h00
`define IRE_MSG_BASE       12'hfee
`define IRE_MAX_IRQ        24
`endif

// ==== design/ire_pkg.sv ====
// types shared by the redirection entry and message launch logic
package ire_pkg;
  typedef enum logic [2:0] {
    IRE_DK_FIXED   = 3'b000,
    IRE_DK_LOWEST  = 3'b001,
    IRE_DK_SMI     = 3'b010,
    IRE_DK_RSVD3   = 3'b011,
    IRE_DK_NMI     = 3'b100,
    IRE_DK_INIT    = 3'b101,
    IRE_DK_RSVD6   = 3'b110,
    IRE_DK_EXTINT  = 3'b111
  } ire_kind_e;

  typedef enum logic [0:0] {
    IRE_ST_IDLE = 1'b0,
    IRE_ST_SEND = 1'b1
  } ire_state_e;
endpackage : ire_pkg

// ==== design/ire_entry.sv ====
// one redirection entry: low and high halves, edge capture and pending flag
`timescale 1ns/1ps
`include "ire_map.svh"
module ire_entry (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [31:0] wdata,
  input  wire logic        ack,
  input  wire logic        irq_in,
  output logic      [31:0] lo_word,
  output logic      [31:0] hi_word,
  output logic             req,
  output logic      [7:0]  interrupt_vector_field,
  output logic      [2:0]  delivery_kind_field,
  output logic             target_addressing_mode,
  output logic      [7:0]  target_identifier,
  output logic      [7:0]  extended_target_identifier
);
  logic [7:0] vec_ff, nxt_vec;
  logic [2:0] delivery_kind_field_ff, nxt_delivery_kind_field;
  logic       target_addressing_mode_ff, nxt_target_addressing_mode;
  logic       mask_ff, nxt_mask;
  logic [7:0] did_ff, nxt_did;
  logic [7:0] extended_target_identifier_ff, nxt_extended_target_identifier;
  logic       pend_ff, nxt_pend;
  logic       irq_ff, nxt_irq;
  logic       supported;
  logic       rise;

  // only fixed and lowest-priority delivery are served; every input is edge-triggered
  assign supported = (delivery_kind_field_ff == ire_pkg::IRE_DK_FIXED) ||
                     (delivery_kind_field_ff == ire_pkg::IRE_DK_LOWEST);
  assign rise      = irq_in & ~irq_ff;

  always_comb begin
    nxt_vec  = vec_ff;
    nxt_delivery_kind_field = delivery_kind_field_ff;
    nxt_target_addressing_mode = target_addressing_mode_ff;
    nxt_mask = mask_ff;
    nxt_did  = did_ff;
    nxt_extended_target_identifier = extended_target_identifier_ff;
    nxt_irq  = irq_in;
    if (wr_lo) begin
      nxt_vec  = wdata[`IRE_VEC_MSB:`IRE_VEC_LSB];
      nxt_delivery_kind_field = wdata[`IRE_DELIVERY_KIND_FIELD_MSB:`IRE_DELIVERY_KIND_FIELD_LSB];
      nxt_target_addressing_mode = wdata[`IRE_TARGET_ADDRESSING_MODE_BIT];
      nxt_mask = wdata[`IRE_MASK_BIT];
    end
    if (wr_hi) begin
      nxt_did  = wdata[`IRE_DID_MSB:`IRE_DID_LSB];
      nxt_extended_target_identifier = wdata[`IRE_EXTENDED_TARGET_IDENTIFIER_MSB:`IRE_EXTENDED_TARGET_IDENTIFIER_LSB];
    end
    nxt_pend = pend_ff;
    if (ack) begin
      nxt_pend = 1'b0;
    end
    // a new edge in the acceptance cycle stays pending
    if (rise && !mask_ff && supported) begin
      nxt_pend = 1'b1;
    end
    // masked inputs hold nothing pending
    if (nxt_mask) begin
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_ff  <= `IRE_VEC_RST;
      delivery_kind_field_ff <= `IRE_DELIVERY_KIND_FIELD_RST;
      target_addressing_mode_ff <= 1'b0;
      mask_ff <= `IRE_MASK_RST;
      did_ff  <= `IRE_ID_RST;
      extended_target_identifier_ff <= `IRE_ID_RST;
      pend_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end else begin
      vec_ff  <= nxt_vec;
      delivery_kind_field_ff <= nxt_delivery_kind_field;
      target_addressing_mode_ff <= nxt_target_addressing_mode;
      mask_ff <= nxt_mask;
      did_ff  <= nxt_did;
      extended_target_identifier_ff <= nxt_extended_target_identifier;
      pend_ff <= nxt_pend;
      irq_ff  <= nxt_irq;
    end
  end

  assign req     = pend_ff & supported & ~mask_ff;
  assign lo_word = {15'h0000, mask_ff, 3'h0, pend_ff, target_addressing_mode_ff, delivery_kind_field_ff, vec_ff};
  assign hi_word = {did_ff, extended_target_identifier_ff, 16'h0000};
  assign interrupt_vector_field     = vec_ff;
  assign delivery_kind_field        = delivery_kind_field_ff;
  assign target_addressing_mode     = target_addressing_mode_ff;
  assign target_identifier          = did_ff;
  assign extended_target_identifier = extended_target_identifier_ff;
endmodule : ire_entry

// ==== test/ire_redirect_chk.sv ====
// concurrent checks on the redirection table ports
`timescale 1ns/1ps
module ire_redirect_chk #(parameter int NUM_IRQ = 24, parameter int ADDR_W = 8) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [NUM_IRQ-1:0] irq_in,
  input wire logic               msg_valid,
  input wire logic               msg_ready,
  input wire logic [31:0]        msg_addr,
  input wire logic [7:0]         msg_vector,
  input wire logic [2:0]         msg_kind,
  input wire logic               msg_logical,
  input wire logic [3:0]         msg_phys_target
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_addr_base: assert property (msg_valid |-> msg_addr[31:20] == 12'hfee)
    else $error("message address base wrong");
  chk_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr))
    else $error("message dropped or changed before acceptance");
  chk_kind_legal: assert property (msg_valid |-> msg_kind inside {3'h0, 3'h1})
    else $error("unsupported delivery kind sent");
  chk_phys_target: assert property (msg_valid && !msg_logical |->
    msg_phys_target == msg_addr[15:12])
    else $error("physical target differs from identifier");
  chk_mode_bit: assert property (msg_valid |-> msg_addr[2] == msg_logical)
    else $error("addressing mode bit wrong");
  chk_idle_gap: assert property (msg_valid && msg_ready |=> !msg_valid)
    else $error("no idle cycle after accepted message");
  chk_hi_zero: assert property (psel && penable && !pwrite && paddr[2] |->
    prdata[15:0] == 16'h0000)
    else $error("reserved high half bits not zero");
  chk_low_err: assert property (psel && penable && paddr[7:6] == 2'b00 |-> pslverr)
    else $error("unmapped index accepted");
  chk_map_ok: assert property (psel && penable && paddr[7:6] != 2'b00 &&
    paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped index refused");
  cover property (msg_valid && msg_ready);
  cover property (psel && penable && pslverr);
  cover property (msg_valid && msg_kind == 3'h1);
endmodule : ire_redirect_chk
bind ire_redirect ire_redirect_chk #(.NUM_IRQ(NUM_IRQ), .ADDR_W(ADDR_W)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_in, .msg_valid,
  .msg_ready, .msg_addr, .msg_vector, .msg_kind, .msg_logical, .msg_phys_target);

// ==== test/ire_lapic.sv ====
// local controller model: takes each message after a set stall
`timescale 1ns/1ps
module ire_lapic (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        msg_valid,
  input  wire logic [31:0] msg_addr,
  input  wire logic [3:0]  stall,
  output logic             msg_ready,
  output logic      [31:0] got_addr,
  output logic      [7:0]  got_cnt
);
  logic [3:0] wait_ff;
  // ready only rises while a message is offered, so it never waits idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff   <= 4'h0;
      msg_ready <= 1'b0;
      got_addr  <= 32'h0;
      got_cnt   <= 8'h0;
    end else if (msg_valid && msg_ready) begin
      msg_ready <= 1'b0;
      wait_ff   <= 4'h0;
      got_addr  <= msg_addr;
      got_cnt   <= got_cnt + 8'h1;
    end else if (msg_valid && wait_ff >= stall) begin
      msg_ready <= 1'b1;
    end else if (msg_valid) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule : ire_lapic

// ==== test/tb_top.sv ====
// self-checking bench of the redirection table
`timescale 1ns/1ps
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, msg_addr, got_addr, rd;
  logic        pready, pslverr, msg_valid, msg_ready, msg_logical, err;
  logic [23:0] irq_in = 0;
  logic [7:0]  msg_vector, got_cnt, n0;
  logic [2:0]  msg_kind;
  logic [3:0]  msg_phys_target, stall = 0;
  int          fail_count = 0, cmp_count = 0;
  always #12.5 pclk = ~pclk;
  ire_redirect uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq_in, .msg_valid, .msg_ready, .msg_addr, .msg_vector, .msg_kind,
    .msg_logical, .msg_phys_target);
  ire_lapic lapic (.pclk, .presetn, .msg_valid, .msg_addr, .stall, .msg_ready, .got_addr,
    .got_cnt);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // starts one edge later so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    check("pready", 32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wait_msg(input logic lvl);
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end while (msg_valid !== lvl && n < 40);
    check("msg wait", 32'(msg_valid), 32'(lvl));
  endtask : wait_msg
  task automatic pulse0;
    n0 = got_cnt;
    irq_in[0] <= 1;
    repeat (12) @(posedge pclk);
    irq_in[0] <= 0;
  endtask : pulse0
  task automatic t_regs;
    apb(0, 8'h40, 0); check("lo0 reset", rd, 32'h0001_0000);
    apb(0, 8'hfc, 0); check("hi23 reset", rd, 32'h0);
    apb(1, 8'hfc, 32'hab12_ffff); apb(0, 8'hfc, 0); check("hi23", rd, 32'hab12_0000);
    apb(0, 8'h3c, 0); check("unmapped err", 32'(err), 32'h1);
  endtask : t_regs
  task automatic t_deliver;
    stall <= 3;
    apb(1, 8'hf8, 32'h0000_00fe);
    irq_in[23] <= 1;
    wait_msg(1);
    check("addr", msg_addr, 32'hfeea_b120);
    check("vector", 32'(msg_vector), 32'hfe);
    check("phys", 32'(msg_phys_target), 32'hb);
    wait_msg(0);
    check("taken addr", got_addr, 32'hfeea_b120);
    irq_in[23] <= 0;
  endtask : t_deliver
  task automatic t_kinds;
    stall <= 1;
    for (int k = 0; k < 8; k++) begin
      apb(1, 8'h40, 32'h20 + 32'(k) * 32'h100);
      pulse0();
      check("kind sent", 32'(got_cnt - n0), (k < 2) ? 32'h1 : 32'h0);
    end
    apb(1, 8'h40, 32'h0001_0020);
    pulse0();
    check("masked sent", 32'(got_cnt - n0), 32'h0);
    apb(0, 8'h40, 0); check("masked lo", rd, 32'h0001_0020);
  endtask : t_kinds
  task automatic t_order;
    stall <= 2;
    apb(1, 8'h48, 32'h31);
    // second entry uses lowest priority and logical addressing
    apb(1, 8'h50, 32'h0000_0932);
    irq_in[2:1] <= 2'b11;
    wait_msg(1);
    check("first vec", 32'(msg_vector), 32'h31);
    check("first addr", msg_addr, 32'hfee0_0000);
    check("first kind", 32'(msg_kind), 32'h0);
    check("first mode", 32'(msg_logical), 32'h0);
    wait_msg(0);
    wait_msg(1);
    check("second vec", 32'(msg_vector), 32'h32);
    check("second kind", 32'(msg_kind), 32'h1);
    check("second mode", 32'(msg_logical), 32'h1);
    check("second addr", msg_addr, 32'hfee0_0004);
    check("second phys", 32'(msg_phys_target), 32'h0);
    wait_msg(0);
    irq_in[2:1] <= 2'b00;
  endtask : t_order
  task automatic results;
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_deliver();
    t_kinds();
    t_order();
    results();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    results();
  end
endmodule : tb_top
